// ### rtl/sps_pkg.sv
// Package of constants for the suspend power signalling block
package sps_pkg;
  // Register offsets (function 0 configuration space, byte address)
  localparam logic [7:0]  GENERAL_CONFIG_OFF      = 8'hB0;
  localparam logic [31:0] GENERAL_CONFIG_RST      = 32'h0000_0000;
  // Field positions in general_config
  localparam int          CFG_EXT_CLOCK_REMAP     = 0;
  localparam int          CFG_DISK_SUPPLY_SPARE   = 1;
  // Own power control register
  localparam logic [7:0]  POWER_CTRL_OFF          = 8'hB4;
  localparam logic [31:0] POWER_CTRL_RST          = 32'h0000_0000;
  localparam int          PWR_STATE_LSB           = 0;
  localparam int          PWR_CPU_HALT            = 2;
  localparam int          PWR_BUS_HALT            = 3;
  localparam int          PWR_CACHE_SLEEP         = 4;
  // General output register, inputs readback
  localparam logic [7:0]  GEN_OUTPUT_OFF          = 8'hB8;
  localparam logic [31:0] GEN_OUTPUT_RST          = 32'h0000_0000;
  localparam logic [7:0]  GEN_INPUT_OFF           = 8'hBC;
  localparam int          GPIO_COUNT              = 15;
  // Index of output 24 and 25 within the 15 general outputs
  localparam int          GEN_OUT_24_IDX          = 8;
  localparam int          GEN_OUT_25_IDX          = 9;
  // X-bus control register
  localparam logic [7:0]  XBUS_CTRL_OFF           = 8'hC0;
  localparam logic [31:0] XBUS_CTRL_RST           = 32'h0000_0000;
  localparam int          XBUS_ENABLE             = 0;
  localparam int          XBUS_DIR                = 1;

  typedef enum logic [1:0] {
    SPS_RUN,
    SPS_POWER_ON_SUSPEND,
    SPS_SUSPEND_TO_RAM,
    SPS_SUSPEND_TO_DISK
  } sps_state_t;
endpackage

// ### rtl/sps_regs.sv
// Register file of the suspend power signalling block
`timescale 1ns/1ps
`default_nettype none
module sps_regs
  import sps_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  // Register contents and observed state
  input  wire logic [14:0] i_general_input,
  input  wire logic [1:0]  i_state,
  output logic      [31:0] o_general_config,
  output logic      [31:0] o_power_ctrl,
  output logic      [31:0] o_gen_output,
  output logic      [31:0] o_xbus_ctrl
);
  logic [31:0] cfg_q;
  logic [31:0] pwr_q;
  logic [31:0] genout_q;
  logic [31:0] xbus_q;
  logic [31:0] rdata_d;

  // Status read shows the live suspend state in bits 9:8
  assign rdata_d = (i_reg_addr == GENERAL_CONFIG_OFF) ? cfg_q :
                   (i_reg_addr == POWER_CTRL_OFF)     ? {22'h0, i_state, pwr_q[7:0]} :
                   (i_reg_addr == GEN_OUTPUT_OFF)     ? {17'h0, genout_q[14:0]} :
                   (i_reg_addr == GEN_INPUT_OFF)      ? {17'h0, i_general_input} :
                   (i_reg_addr == XBUS_CTRL_OFF)      ? {30'h0, xbus_q[1:0]} : 32'h0;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cfg_q       <= GENERAL_CONFIG_RST;
      pwr_q       <= POWER_CTRL_RST;
      genout_q    <= GEN_OUTPUT_RST;
      xbus_q      <= XBUS_CTRL_RST;
      o_reg_rdata <= 32'h0;
    end else begin
      o_reg_rdata <= rdata_d;
      if (i_reg_wr && i_reg_addr == GENERAL_CONFIG_OFF) cfg_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == POWER_CTRL_OFF) pwr_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == GEN_OUTPUT_OFF) genout_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == XBUS_CTRL_OFF) xbus_q <= i_reg_wdata;
    end
  end

  assign o_general_config = cfg_q;
  assign o_power_ctrl     = pwr_q;
  assign o_gen_output     = genout_q;
  assign o_xbus_ctrl      = xbus_q;
endmodule
`default_nettype wire

// ### rtl/sps_top.sv
// Suspend and power control signalling toward the board
`timescale 1ns/1ps
`default_nettype none
module sps_top
  import sps_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_resume_well_reset_n,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  // Power signalling
  output logic             o_suspend_out_a_n,
  output logic             o_suspend_out_c_n,
  output logic             o_processor_clock_halt_n,
  output logic             o_bus_clock_halt_n,
  output logic             o_cache_sleep,
  // General purpose pins and remapped clock chip pins
  input  wire logic [14:0] i_general_input,
  output logic      [14:0] o_general_output,
  input  wire logic        i_ext_clock_select_n,
  input  wire logic        i_ext_clock_addr_latch,
  output logic             o_ext_clock_select_n,
  output logic             o_ext_clock_addr_latch,
  // X-bus transceiver
  output logic             o_xbus_output_enable_n,
  output logic             o_xbus_direction
);
  logic [31:0] cfg;
  logic [31:0] pwr;
  logic [31:0] genout;
  logic [31:0] xbus;
  sps_state_t  state_q;
  sps_state_t  state_d;
  logic        in_suspend;
  logic        remap_mode;
  logic [14:0] genout_d;
  logic        rst_seen_q;

  // Suspend-to-disk decode, shared by the output stage and its checks
  function automatic logic is_disk(input sps_state_t s);
    return s == SPS_SUSPEND_TO_DISK;
  endfunction

  // Internal resume reset combined: both resets idle the power outputs
  logic rst_all_n;
  assign rst_all_n = i_rst_n & i_resume_well_reset_n;

  sps_regs u_regs (
    .i_clk_sys        (i_clk_sys),
    .i_rst_n          (rst_all_n),
    .i_reg_wr         (i_reg_wr),
    .i_reg_addr       (i_reg_addr),
    .i_reg_wdata      (i_reg_wdata),
    .o_reg_rdata      (o_reg_rdata),
    .i_general_input  (i_general_input),
    .i_state          (state_q),
    .o_general_config (cfg),
    .o_power_ctrl     (pwr),
    .o_gen_output     (genout),
    .o_xbus_ctrl      (xbus)
  );

  assign state_d    = sps_state_t'(pwr[PWR_STATE_LSB +: 2]);
  assign in_suspend = (state_q != SPS_RUN);

  assign remap_mode = cfg[CFG_EXT_CLOCK_REMAP];
  // all fifteen outputs usable as general outputs
  assign genout_d   = genout[14:0];

  always_ff @(posedge i_clk_sys) begin
    if (!rst_all_n) begin
      state_q <= SPS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Set once reset has been seen; keeps the idle checks off the
  // very first edge, when the outputs are still unknown
  always_ff @(posedge i_clk_sys) begin
    if (!rst_all_n) begin
      rst_seen_q <= 1'b1;
    end
  end

  // outputs registered; active-low outputs idle high, the others low after reset
  always_ff @(posedge i_clk_sys) begin
    if (!rst_all_n) begin
      o_suspend_out_a_n        <= 1'b1;
      o_suspend_out_c_n        <= 1'b1;
      o_processor_clock_halt_n <= 1'b1;
      o_bus_clock_halt_n       <= 1'b1;
      o_cache_sleep            <= 1'b0;
      o_general_output         <= 15'h0;
      o_ext_clock_select_n     <= 1'b1;
      o_ext_clock_addr_latch   <= 1'b0;
      o_xbus_output_enable_n   <= 1'b1;
      o_xbus_direction         <= 1'b0;
    end else begin
      // low in any suspend state; feeds clock generator power-down
      o_suspend_out_a_n        <= ~in_suspend;
      o_suspend_out_c_n        <= ~is_disk(state_q);
      o_processor_clock_halt_n <= ~pwr[PWR_CPU_HALT];
      o_bus_clock_halt_n       <= ~pwr[PWR_BUS_HALT];
      o_cache_sleep            <= pwr[PWR_CACHE_SLEEP];
      o_general_output         <= genout_d;
      // pins follow outputs 24/25 when remapped
      o_ext_clock_select_n     <= remap_mode ? genout_d[GEN_OUT_24_IDX] : i_ext_clock_select_n;
      o_ext_clock_addr_latch   <= remap_mode ? genout_d[GEN_OUT_25_IDX] : i_ext_clock_addr_latch;
      o_xbus_output_enable_n   <= ~xbus[XBUS_ENABLE];
      o_xbus_direction         <= xbus[XBUS_DIR];
    end
  end

  susp_a_level_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_suspend_out_a_n == ($past(state_q) == SPS_RUN)))
    else $error("first suspend output wrong");

  susp_c_disk_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) && !o_suspend_out_c_n |-> !o_suspend_out_a_n)
    else $error("third suspend without first");

  susp_c_level_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_suspend_out_c_n == !is_disk($past(state_q))))
    else $error("third suspend output wrong");

  state_load_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (state_q == sps_state_t'($past(pwr[PWR_STATE_LSB +: 2]))))
    else $error("suspend state not loaded");

  state_read_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) && ($past(i_reg_addr) == POWER_CTRL_OFF)
      |-> (o_reg_rdata[9:8] == 2'($past(state_q))))
    else $error("suspend state readback wrong");

  cpu_halt_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_processor_clock_halt_n == !$past(pwr[PWR_CPU_HALT])))
    else $error("processor clock halt wrong");

  bus_halt_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_bus_clock_halt_n == !$past(pwr[PWR_BUS_HALT])))
    else $error("bus clock halt wrong");

  cache_sleep_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_cache_sleep == $past(pwr[PWR_CACHE_SLEEP])))
    else $error("cache sleep wrong");

  clk_remap_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) && $past(remap_mode)
      |-> (o_ext_clock_select_n == $past(genout[GEN_OUT_24_IDX])))
    else $error("clock select remap wrong");

  latch_remap_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) && $past(remap_mode)
      |-> (o_ext_clock_addr_latch == $past(genout[GEN_OUT_25_IDX])))
    else $error("address latch remap wrong");

  native_pins_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) && !$past(remap_mode)
      |-> ((o_ext_clock_select_n == $past(i_ext_clock_select_n))
           && (o_ext_clock_addr_latch == $past(i_ext_clock_addr_latch))))
    else $error("native clock pins wrong");

  gen_out_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_general_output == $past(genout_d)))
    else $error("general outputs wrong");

  xbus_en_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_xbus_output_enable_n == !$past(xbus[XBUS_ENABLE])))
    else $error("xbus enable wrong");

  xbus_dir_a: assert property (@(posedge i_clk_sys) disable iff (!rst_all_n)
    $past(rst_all_n) |-> (o_xbus_direction == $past(xbus[XBUS_DIR])))
    else $error("xbus direction wrong");

  reset_idle_a: assert property (@(posedge i_clk_sys)
    rst_seen_q && !$past(rst_all_n)
      |-> (o_suspend_out_a_n && o_suspend_out_c_n && o_processor_clock_halt_n
           && o_bus_clock_halt_n && !o_cache_sleep))
    else $error("outputs not idle after reset");

  pins_idle_a: assert property (@(posedge i_clk_sys)
    rst_seen_q && !$past(rst_all_n)
      |-> (o_xbus_output_enable_n && !o_xbus_direction && (o_general_output == 15'h0)))
    else $error("pins not idle after reset");
endmodule
`default_nettype wire

// ### verif/sps_board_model.sv
// Board-side model: clock generator, supply inverter, cache SRAM, X-bus transceiver
`timescale 1ns/1ps
`default_nettype none
module sps_board_model (
  // From the device
  input  wire logic i_suspend_out_a_n,
  input  wire logic i_suspend_out_c_n,
  input  wire logic i_processor_clock_halt_n,
  input  wire logic i_bus_clock_halt_n,
  input  wire logic i_cache_sleep,
  input  wire logic i_xbus_output_enable_n,
  input  wire logic i_xbus_direction,
  // Drive activity lines from the disks
  input  wire logic i_disk_activity_first_n,
  input  wire logic i_disk_activity_second_n,
  // Board state
  output logic      o_clkgen_running,
  output logic      o_cpu_clk_on,
  output logic      o_bus_clk_on,
  output logic      o_supply_on_request_n,
  output logic      o_cache_low_power,
  output logic      o_xbus_driving,
  output logic      o_xbus_toward_card,
  output logic      o_disk_led_on
);
  // either drive active lights the indicator
  assign o_disk_led_on = ~(i_disk_activity_first_n & i_disk_activity_second_n);
  assign o_clkgen_running = i_suspend_out_a_n;
  assign o_cpu_clk_on = i_clkgen_ok(i_processor_clock_halt_n);
  assign o_bus_clk_on = i_clkgen_ok(i_bus_clock_halt_n);
  assign o_supply_on_request_n = ~i_suspend_out_c_n;
  assign o_cache_low_power = i_cache_sleep;
  assign o_xbus_driving = ~i_xbus_output_enable_n;
  assign o_xbus_toward_card = i_xbus_direction;
  // Clocks run only while not halted and the generator itself still runs
  function automatic logic i_clkgen_ok(input logic halt_n);
    return halt_n & i_suspend_out_a_n;
  endfunction
endmodule
`default_nettype wire

// ### verif/sps_top_tb.sv
// Self-checking testbench of the suspend power signalling block
`timescale 1ns/1ps
`default_nettype none
module sps_top_tb
  import sps_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, rw_n = 1'b0, wr = 1'b0, sel_n = 1'b1, ale = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [14:0] gi = 15'h0000;
  wire  logic [31:0] rd;
  wire  logic [14:0] go;
  logic        d1_n = 1'b1, d2_n = 1'b1;
  wire  logic  sa, sc, ch, bh, slp, sn, al, xe, xd, pwr, cpu, bus, son, lp, xdrv, xtow, led;
  int          mismatches = 0, checks_done = 0;

  sps_top u_sps_top (.i_clk_sys(clk), .i_rst_n(rst_n), .i_resume_well_reset_n(rw_n),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd),
    .o_suspend_out_a_n(sa), .o_suspend_out_c_n(sc), .o_processor_clock_halt_n(ch),
    .o_bus_clock_halt_n(bh), .o_cache_sleep(slp), .i_general_input(gi),
    .o_general_output(go), .i_ext_clock_select_n(sel_n), .i_ext_clock_addr_latch(ale),
    .o_ext_clock_select_n(sn), .o_ext_clock_addr_latch(al),
    .o_xbus_output_enable_n(xe), .o_xbus_direction(xd));
  sps_board_model u_sps_board_model (.i_suspend_out_a_n(sa), .i_suspend_out_c_n(sc),
    .i_processor_clock_halt_n(ch), .i_bus_clock_halt_n(bh), .i_cache_sleep(slp),
    .i_xbus_output_enable_n(xe), .i_xbus_direction(xd), .o_clkgen_running(pwr),
    .o_cpu_clk_on(cpu), .o_bus_clk_on(bus), .o_supply_on_request_n(son),
    .o_cache_low_power(lp), .o_xbus_driving(xdrv), .o_xbus_toward_card(xtow),
    .i_disk_activity_first_n(d1_n), .i_disk_activity_second_n(d2_n),
    .o_disk_led_on(led));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One-cycle write strobe, then one idle cycle so writes never abut
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    addr = a;
    cyc(1);
    chk(rd, e, m);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    // resume-well reset held past one millisecond
    cyc(20);
    rst_n = 1'b1;
    cyc(25000);
    chk({sa, sc, ch, bh, slp, xe, xd}, 7'b1111010, "levels in resume reset");
    rw_n = 1'b1;
    cyc(1);
    chk({sa, sc, ch, bh, slp, xe, xd}, 7'b1111010, "levels after reset");
    rd_chk(GENERAL_CONFIG_OFF, GENERAL_CONFIG_RST, "config reset value");
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr_reg(POWER_CTRL_OFF, 32'(s));
      cyc(3);
      chk({sa, pwr}, {2{s == 0}}, "suspend a and generator");
      chk({sc, son}, {s != 3, s == 3}, "suspend c and supply");
      rd_chk(POWER_CTRL_OFF, 32'(s) | (32'(s) << 8), "live state readback");
    end
    wr_reg(POWER_CTRL_OFF, 32'h0000_001C);
    cyc(3);
    chk({ch, bh, slp, cpu, bus, lp}, 6'b001001, "halts and sleep");
    rd_chk(POWER_CTRL_OFF, 32'h0000_001C, "power ctrl readback");
    $display("test power done");
    for (int x = 0; x < 4; x++) begin
      wr_reg(XBUS_CTRL_OFF, 32'(x));
      cyc(2);
      chk({xe, xd, xdrv, xtow}, {~x[0], x[1], x[0], x[1]}, "xbus control");
    end
    $display("test xbus done");
    gi = 15'h5A3C;
    sel_n = 1'b0;
    ale = 1'b1;
    wr_reg(GEN_OUTPUT_OFF, 32'h0000_2AD5);
    cyc(2);
    chk(go, 15'h2AD5, "general outputs");
    rd_chk(GEN_INPUT_OFF, 32'h0000_5A3C, "general inputs");
    chk({sn, al}, 2'b01, "native clock pins");
    wr_reg(GENERAL_CONFIG_OFF, 32'h0000_0001);
    wr_reg(GEN_OUTPUT_OFF, 32'h0000_0100);
    cyc(2);
    chk({sn, al}, 2'b10, "remapped clock pins");
    rd_chk(GENERAL_CONFIG_OFF, 32'h0000_0001, "config readback");
    wr_reg(8'hF0, 32'hFFFF_FFFF);
    rd_chk(8'hF0, 32'h0000_0000, "unmapped address");
    $display("test pins done");
    wr_reg(POWER_CTRL_OFF, 32'h0000_0003);
    cyc(3);
    chk({sa, sc, son}, 3'b001, "disk before resume reset");
    rw_n = 1'b0;
    cyc(2);
    rw_n = 1'b1;
    cyc(1);
    chk({sa, sc, ch, bh}, 4'hF, "levels after resume reset");
    rd_chk(POWER_CTRL_OFF, 32'h0000_0000, "power ctrl after resume reset");
    $display("test resume done");
    for (int d = 0; d < 4; d++) begin
      d1_n = d[0];
      d2_n = d[1];
      cyc(1);
      chk(led, d != 3, "disk activity indicator");
    end
    $display("test disk done");
    print_verdict();
  end
endmodule
`default_nettype wire
